// *** pkg/sisc_pkg.sv ***
// Shared constants, register map and carrier types of the safety input
// and start control block. Assumes a 125 MHz aclk for all timing counts.

package sisc_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_PAIRS = 6;
  localparam int NUM_OUT = 2;
  localparam int SEL_W = 3;
  localparam int CNT_W = 27;
  localparam int ADDR_W = 12;

  typedef logic [CNT_W-1:0] sisc_cnt_t;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 125_000_000;
  localparam int SYNC_WIN_MS = 500;
  localparam int START_MIN_MS = 80;
  localparam int TEST_PULSE_US = 1000;
  localparam sisc_cnt_t SYNC_WIN_CYC = sisc_cnt_t'(SYNC_WIN_MS * (CLK_HZ / 1000));
  localparam sisc_cnt_t START_MIN_CYC = sisc_cnt_t'(START_MIN_MS * (CLK_HZ / 1000));
  localparam sisc_cnt_t TEST_PULSE_CYC = sisc_cnt_t'(TEST_PULSE_US * (CLK_HZ / 1_000_000));
  localparam logic [3:0] INIT_CYC = 4'h8;

  // ==========================================================================
  // Register map and fields
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] REG_PAIR = 12'h004;
  localparam logic [ADDR_W-1:0] REG_FCLR = 12'h008;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_OUT_BIT = 4;
  localparam int ST_SEL_LSB = 5;
  localparam int ST_MON_BIT = 8;
  localparam int ST_TEST_BIT = 9;
  localparam int ST_DYN_BIT = 10;
  localparam int ST_DONE_LSB = 16;
  localparam int PR_ACT_LSB = 0;
  localparam int PR_SYNC_LSB = 8;
  localparam int PR_ILK_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    ST_INIT = 4'h1,
    ST_TEST = 4'h2,
    ST_OFF = 4'h4,
    ST_ON = 4'h8
  } sisc_state_t;

  typedef struct packed {
    logic monitored;
    logic test;
    logic dyn;
  } sisc_cfg_t;

  typedef struct packed {
    logic active;
    logic sync_fault;
    logic ilk_fault;
  } sisc_pair_t;

  localparam sisc_cfg_t CFG_RST = 3'h0;

endpackage

// *** hdl/sisc_pair_mon.sv ***
// Verdict for one two-channel input fed by self-testing switching outputs.
// Assumes both channels are already synchronised and filtered to aclk.

`timescale 1ns/1ps

module sisc_pair_mon #(
  parameter sisc_pkg::sisc_cnt_t SYNC_CYC = sisc_pkg::SYNC_WIN_CYC,
  parameter sisc_pkg::sisc_cnt_t TP_CYC = sisc_pkg::TEST_PULSE_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Filtered channels
  input wire logic ch_a,
  input wire logic ch_b,
  // Software clear of the cross-connection flag
  input wire logic ilk_clr,
  // Verdict
  output sisc_pkg::sisc_pair_t stat
);

  logic both_hi;
  logic both_lo;
  logic short_seen;
  logic prev_hi_q;
  logic dip_on_q;
  logic sync_q;
  logic ilk_q;
  logic act_q;
  sisc_pkg::sisc_cnt_t skew_q;
  sisc_pkg::sisc_cnt_t lo_q;

  assign both_hi = ch_a & ch_b;
  assign both_lo = ~ch_a & ~ch_b;
  // Staggered self-test pulses never dip both channels together briefly
  assign short_seen = dip_on_q & both_hi & (lo_q < TP_CYC);

  // ==========================================================================
  // Channel skew
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skew_q <= '0;
    end else if (ch_a ^ ch_b) begin
      if (skew_q != SYNC_CYC) begin
        skew_q <= skew_q + 1'b1;
      end
    end else begin
      skew_q <= '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_q <= 1'b0;
    end else if (skew_q == SYNC_CYC) begin
      sync_q <= 1'b1;
    end else if (both_lo) begin
      sync_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Low time and cross-connection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_q <= '0;
      prev_hi_q <= 1'b0;
      dip_on_q <= 1'b0;
    end else begin
      prev_hi_q <= both_hi;
      if (both_hi) begin
        lo_q <= '0;
      end else if (lo_q != TP_CYC) begin
        lo_q <= lo_q + 1'b1;
      end
      if (prev_hi_q && both_lo) begin
        dip_on_q <= 1'b1;
      end else if (!both_lo) begin
        dip_on_q <= 1'b0;
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ilk_q <= 1'b0;
    end else if (short_seen) begin
      ilk_q <= 1'b1;
    end else if (ilk_clr) begin
      ilk_q <= 1'b0;
    end
  end

  // Short self-test dips do not drop the pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_q <= 1'b0;
    end else if (sync_q || ilk_q || short_seen || lo_q == TP_CYC) begin
      act_q <= 1'b0;
    end else if (both_hi) begin
      act_q <= 1'b1;
    end
  end

  assign stat = '{active: act_q, sync_fault: sync_q, ilk_fault: ilk_q};

endmodule

// *** hdl/sisc_top.sv ***
// Evaluation of six two-channel safety inputs and the start input, driving
// the safety outputs, with an AXI4-Lite register port. Assumes one 125 MHz
// clock; sensor, start and selector pins are asynchronous to it.

`timescale 1ns/1ps

module sisc_top #(
  parameter sisc_pkg::sisc_cnt_t SYNC_CYC = sisc_pkg::SYNC_WIN_CYC,
  parameter sisc_pkg::sisc_cnt_t START_CYC = sisc_pkg::START_MIN_CYC,
  parameter sisc_pkg::sisc_cnt_t TP_CYC = sisc_pkg::TEST_PULSE_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sensor channels, start input and start selector
  input wire logic [sisc_pkg::NUM_PAIRS-1:0] ch_a,
  input wire logic [sisc_pkg::NUM_PAIRS-1:0] ch_b,
  input wire logic start_in,
  input wire logic [sisc_pkg::SEL_W-1:0] start_sel,
  // Safety outputs and fault summary
  output logic [sisc_pkg::NUM_OUT-1:0] safe_out,
  output logic fault_out,
  // AXI4-Lite write
  input wire logic [sisc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [sisc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int NP = sisc_pkg::NUM_PAIRS;
  localparam int IN_W = 2 * NP + 1 + sisc_pkg::SEL_W;
  localparam int START_BIT = 2 * NP;
  localparam int SEL_LSB = 2 * NP + 1;

  // Selector positions 1..8 arrive as codes 0..7
  function automatic sisc_pkg::sisc_cfg_t sel_decode(input logic [sisc_pkg::SEL_W-1:0] s);
    sisc_pkg::sisc_cfg_t c;
    c.monitored = s[1];
    c.test = s[0];
    c.dyn = ~s[2];
    return c;
  endfunction

  function automatic logic reg_mapped(input logic [sisc_pkg::ADDR_W-1:0] a);
    logic [sisc_pkg::ADDR_W-1:0] w;
    w = {a[sisc_pkg::ADDR_W-1:2], 2'h0};
    return w == sisc_pkg::REG_STATUS || w == sisc_pkg::REG_PAIR || w == sisc_pkg::REG_FCLR;
  endfunction

  // ==========================================================================
  // Pin synchronisers
  logic [IN_W-1:0] s1_q;
  logic [IN_W-1:0] s2_q;
  logic [IN_W-1:0] s3_q;
  logic [IN_W-1:0] filt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
    end else begin
      s1_q <= {start_sel, start_in, ch_b, ch_a};
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Take a level only once the last two stages agree
      filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
    end
  end

  // ==========================================================================
  // Pair monitors
  sisc_pkg::sisc_pair_t pair [NP];
  logic [NP-1:0] pair_act;
  logic [NP-1:0] pair_sync;
  logic [NP-1:0] pair_ilk;
  logic [NP-1:0] ilk_clr;

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_pair
      sisc_pair_mon #(
        .SYNC_CYC(SYNC_CYC),
        .TP_CYC(TP_CYC)
      ) u_mon (
        .aclk(aclk),
        .aresetn(aresetn),
        .ch_a(filt_q[gi]),
        .ch_b(filt_q[NP+gi]),
        .ilk_clr(ilk_clr[gi]),
        .stat(pair[gi])
      );
      assign pair_act[gi] = pair[gi].active;
      assign pair_sync[gi] = pair[gi].sync_fault;
      assign pair_ilk[gi] = pair[gi].ilk_fault;
    end
  endgenerate

  // ==========================================================================
  // Start input tracking
  logic start_lvl;
  logic st_prev_q;
  logic st_rise;
  logic st_fall;
  logic armed_q;
  logic pulse_long;
  sisc_pkg::sisc_cnt_t pulse_q;

  assign start_lvl = filt_q[START_BIT];
  assign st_rise = start_lvl & ~st_prev_q;
  assign st_fall = ~start_lvl & st_prev_q;
  assign pulse_long = pulse_q >= START_CYC;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_prev_q <= 1'b0;
      pulse_q <= '0;
    end else begin
      st_prev_q <= start_lvl;
      if (!start_lvl) begin
        pulse_q <= '0;
      end else if (pulse_q != START_CYC) begin
        pulse_q <= pulse_q + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Start state machine
  sisc_pkg::sisc_state_t state_q;
  sisc_pkg::sisc_state_t state_d;
  sisc_pkg::sisc_cfg_t cfg_q;
  logic [sisc_pkg::SEL_W-1:0] sel_q;
  logic [3:0] init_q;
  logic [NP-1:0] done_q;
  logic all_act;
  logic init_end;
  logic go_on;

  assign all_act = &pair_act;
  assign init_end = init_q == sisc_pkg::INIT_CYC;

  always_comb begin
    if (cfg_q.monitored) begin
      // Falling edge of a long enough pulse with inputs already good
      go_on = st_fall & pulse_long & all_act;
    end else begin
      go_on = all_act & start_lvl & (~cfg_q.dyn | armed_q | st_rise);
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      sisc_pkg::ST_INIT: begin
        if (init_end) begin
          state_d = sel_decode(filt_q[SEL_LSB +: sisc_pkg::SEL_W]).test ?
                    sisc_pkg::ST_TEST : sisc_pkg::ST_OFF;
        end
      end
      sisc_pkg::ST_TEST: begin
        if (&(done_q | ~pair_act)) begin
          state_d = sisc_pkg::ST_OFF;
        end
      end
      sisc_pkg::ST_OFF: begin
        if (go_on) begin
          state_d = sisc_pkg::ST_ON;
        end
      end
      sisc_pkg::ST_ON: begin
        if (!all_act) begin
          state_d = sisc_pkg::ST_OFF;
        end
      end
      default: begin
        state_d = sisc_pkg::ST_INIT;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= sisc_pkg::ST_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  // Selector is sampled once, after the synchronisers have settled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_q <= 4'h0;
      cfg_q <= sisc_pkg::CFG_RST;
      sel_q <= '0;
    end else if (state_q == sisc_pkg::ST_INIT && !init_end) begin
      init_q <= init_q + 4'h1;
    end else if (state_q == sisc_pkg::ST_INIT) begin
      sel_q <= filt_q[SEL_LSB +: sisc_pkg::SEL_W];
      cfg_q <= sel_decode(filt_q[SEL_LSB +: sisc_pkg::SEL_W]);
    end
  end

  // Inputs inactive at power-up count as already tested
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= '0;
    end else if (state_q == sisc_pkg::ST_INIT) begin
      done_q <= ~pair_act;
    end else if (state_q == sisc_pkg::ST_TEST) begin
      done_q <= done_q | ~pair_act;
    end
  end

  // A start press counts only while waiting in the off state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
    end else if (state_q != sisc_pkg::ST_OFF) begin
      armed_q <= 1'b0;
    end else if (st_rise) begin
      armed_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      safe_out <= '0;
      fault_out <= 1'b0;
    end else begin
      safe_out <= {sisc_pkg::NUM_OUT{state_d == sisc_pkg::ST_ON}};
      fault_out <= |pair_sync | |pair_ilk;
    end
  end

  // ==========================================================================
  // AXI4-Lite write
  logic [sisc_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic wr_fire;

  assign wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign ilk_clr = (wr_fire && wstrb0_q && {awaddr_q[11:2], 2'h0} == sisc_pkg::REG_FCLR) ?
                   wdata_q[NP-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awaddr_q <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wdata_q <= s_axi_wdata;
      wstrb0_q <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sisc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= reg_mapped(awaddr_q) ? sisc_pkg::RESP_OKAY : sisc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // AXI4-Lite read
  logic [31:0] st_word;
  logic [31:0] pr_word;
  logic [31:0] rd_word;
  logic [sisc_pkg::ADDR_W-1:0] rd_addr;

  always_comb begin
    st_word = '0;
    st_word[sisc_pkg::ST_STATE_LSB +: 4] = state_q;
    st_word[sisc_pkg::ST_OUT_BIT] = safe_out[0];
    st_word[sisc_pkg::ST_SEL_LSB +: sisc_pkg::SEL_W] = sel_q;
    st_word[sisc_pkg::ST_MON_BIT] = cfg_q.monitored;
    st_word[sisc_pkg::ST_TEST_BIT] = cfg_q.test;
    st_word[sisc_pkg::ST_DYN_BIT] = cfg_q.dyn;
    st_word[sisc_pkg::ST_DONE_LSB +: NP] = done_q;
    pr_word = '0;
    pr_word[sisc_pkg::PR_ACT_LSB +: NP] = pair_act;
    pr_word[sisc_pkg::PR_SYNC_LSB +: NP] = pair_sync;
    pr_word[sisc_pkg::PR_ILK_LSB +: NP] = pair_ilk;
    rd_addr = {s_axi_araddr[11:2], 2'h0};
    if (rd_addr == sisc_pkg::REG_STATUS) begin
      rd_word = st_word;
    end else if (rd_addr == sisc_pkg::REG_PAIR) begin
      rd_word = pr_word;
    end else begin
      rd_word = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= sisc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= reg_mapped(s_axi_araddr) ? sisc_pkg::RESP_OKAY : sisc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// *** test/sisc_sensor_model.sv ***
// Six sensor pairs with self-testing switching outputs, seen at the pins.
// Assumes the bench commands which pairs are on, skewed or shorted.
`timescale 1ns/1ps
module sisc_sensor_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Commands
  input wire logic [5:0] want_on,
  input wire logic [5:0] skew,
  input wire logic [5:0] short_en,
  // Channels
  output logic [5:0] ch_a,
  output logic [5:0] ch_b
);
  // ========================================
  // Test pulses, staggered so a healthy pair never dips on both channels
  logic [6:0] tick_q;
  logic dip_a, dip_b, dip_s;
  always_ff @(posedge aclk) begin
    tick_q <= aresetn ? tick_q + 7'h01 : 7'h00;
  end
  assign dip_a = tick_q inside {[7'h0a:7'h0c]};
  assign dip_b = tick_q inside {[7'h32:7'h34]};
  assign dip_s = tick_q inside {[7'h5a:7'h5c]};
  // One command per pair, all six wired
  assign ch_a = want_on & ~({6{dip_a}} & ~skew) & ~({6{dip_s}} & short_en);
  assign ch_b = want_on & ~skew & ~{6{dip_b}} & ~({6{dip_s}} & short_en);
endmodule

// *** test/sisc_top_chk.sv ***
// Pin-level checker for the safety input and start control top.
// Assumes the selector pins stay put while reset is released.
`timescale 1ns/1ps
module sisc_top_chk #(
  parameter sisc_pkg::sisc_cnt_t SYNC_CYC = sisc_pkg::SYNC_WIN_CYC,
  parameter sisc_pkg::sisc_cnt_t START_CYC = sisc_pkg::START_MIN_CYC,
  parameter sisc_pkg::sisc_cnt_t TP_CYC = sisc_pkg::TEST_PULSE_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins
  input wire logic [sisc_pkg::NUM_PAIRS-1:0] ch_a,
  input wire logic [sisc_pkg::NUM_PAIRS-1:0] ch_b,
  input wire logic start_in,
  input wire logic [sisc_pkg::SEL_W-1:0] start_sel,
  input wire logic [sisc_pkg::NUM_OUT-1:0] safe_out,
  input wire logic fault_out
);
  // ========================================
  // Run lengths of pin levels
  sisc_pkg::sisc_cnt_t lo_q [12];
  sisc_pkg::sisc_cnt_t df_q [6];
  sisc_pkg::sisc_cnt_t hi_s_q, lo_s_q, pls_q, qt_q;
  logic [5:0] a_p_q, b_p_q, co_q, seen_q, ilk_ev;
  logic long_low, quiet, sy_long;
  logic [11:0] pins;
  assign pins = {ch_b, ch_a};
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 12; i++) begin
      lo_q[i] <= (pins[i] || !aresetn) ? '0 : lo_q[i] + 27'h1;
    end
    for (int i = 0; i < 6; i++) begin
      df_q[i] <= (ch_a[i] != ch_b[i] && aresetn) ? df_q[i] + 27'h1 : '0;
    end
  end
  always_ff @(posedge aclk) begin
    hi_s_q <= (start_in && aresetn) ? hi_s_q + 27'h1 : '0;
    lo_s_q <= (!start_in && aresetn) ? lo_s_q + 27'h1 : '0;
    pls_q <= !aresetn ? '0 : (!start_in && hi_s_q != '0) ? hi_s_q : pls_q;
  end
  // Short dips are ignored by the block, so only long lows count as a cycle
  always_ff @(posedge aclk) begin
    a_p_q <= ch_a;
    b_p_q <= ch_b;
    co_q <= ~ch_a & ~ch_b & ((a_p_q & b_p_q) | co_q);
    qt_q <= (quiet && aresetn) ? qt_q + 27'h1 : '0;
    for (int i = 0; i < 6; i++) begin
      seen_q[i] <= aresetn ? (seen_q[i] | (lo_q[i] >= TP_CYC - 27'h2)
        | (lo_q[i+6] >= TP_CYC - 27'h2)) : ~(ch_a[i] & ch_b[i]);
    end
  end
  always_comb begin
    long_low = 1'b0;
    quiet = 1'b1;
    sy_long = 1'b0;
    for (int i = 0; i < 12; i++) begin
      long_low = long_low | (lo_q[i] >= TP_CYC + 27'h10);
      quiet = quiet & (lo_q[i] < 27'h4);
    end
    for (int i = 0; i < 6; i++) begin
      sy_long = sy_long | (df_q[i] >= SYNC_CYC + 27'hc);
      ilk_ev[i] = co_q[i] & ch_a[i] & ch_b[i] & (lo_q[i] < TP_CYC - 27'h2);
    end
  end
  // ========================================
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  out_pair_a: assert property (safe_out[0] == safe_out[1])
    else $error("safety outputs differ");
  rst_off_a: assert property ($rose(aresetn) |-> safe_out == 2'h0 && !fault_out)
    else $error("outputs not off after reset");
  drop_off_a: assert property (long_low |-> safe_out == 2'h0)
    else $error("outputs on with a channel long low");
  sync_flt_a: assert property (sy_long |-> fault_out)
    else $error("channel skew not flagged");
  ilk_flt_a: assert property (|ilk_ev |-> ##[1:12] fault_out)
    else $error("coincident dip not flagged");
  auto_on_a: assert property (start_sel == 3'h4 && qt_q == 27'h28
    && hi_s_q >= 27'h1e && !fault_out |-> ##[1:24] safe_out[0])
    else $error("automatic start too slow");
  man_on_a: assert property (start_sel[1:0] == 2'h0 && $rose(start_in)
    && qt_q > 27'h28 && !fault_out |-> ##[1:24] safe_out[0])
    else $error("manual start too slow");
  man_need_a: assert property ($rose(safe_out[0]) && !start_sel[1]
    |-> lo_s_q < 27'hc)
    else $error("energized without start");
  mon_len_a: assert property ($rose(safe_out[0]) && start_sel[1]
    |-> lo_s_q > '0 && lo_s_q < 27'h10 && pls_q >= START_CYC - 27'h2)
    else $error("monitored start without long pulse");
  mon_on_a: assert property (start_sel[1:0] == 2'h2 && $fell(start_in)
    && hi_s_q >= START_CYC + 27'h4 && qt_q > 27'h28 && !fault_out
    |-> ##[1:24] safe_out[0])
    else $error("monitored start too slow");
  test_gate_a: assert property (start_sel[0] && $rose(safe_out[0]) |-> &seen_q)
    else $error("startup test skipped");
  mon_c: cover property ($rose(safe_out[0]) && start_sel[1]);
  ilk_c: cover property (|ilk_ev);
  test_c: cover property ($rose(safe_out[0]) && start_sel[0]);
endmodule

bind sisc_top sisc_top_chk #(.SYNC_CYC(SYNC_CYC), .START_CYC(START_CYC), .TP_CYC(TP_CYC))
  i_sisc_top_chk (.aclk(aclk), .aresetn(aresetn), .ch_a(ch_a), .ch_b(ch_b),
  .start_in(start_in), .start_sel(start_sel), .safe_out(safe_out), .fault_out(fault_out));

// *** test/sisc_test.sv ***
// Self-checking bench for the safety input and start control top.
// Assumes the sensor model beside it and the bound pin checker.
`timescale 1ns/1ps
module sisc_test;
  localparam sisc_pkg::sisc_cnt_t SYNC = 27'hc8;
  localparam sisc_pkg::sisc_cnt_t STRT = 27'h64;
  localparam sisc_pkg::sisc_cnt_t TP = 27'h14;
  logic aclk, aresetn, start_in, fault_out;
  logic [2:0] start_sel;
  logic [5:0] ch_a, ch_b, want_on, skew, short_en;
  logic [1:0] safe_out, bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  int n_mismatch, checks_done;
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  sisc_sensor_model i_sisc_sensor_model (.aclk(aclk), .aresetn(aresetn), .want_on(want_on),
    .skew(skew), .short_en(short_en), .ch_a(ch_a), .ch_b(ch_b));
  sisc_top #(.SYNC_CYC(SYNC), .START_CYC(STRT), .TP_CYC(TP)) i_sisc_top (
    .aclk(aclk), .aresetn(aresetn), .ch_a(ch_a), .ch_b(ch_b), .start_in(start_in),
    .start_sel(start_sel), .safe_out(safe_out), .fault_out(fault_out),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ========================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1) && t < 50);
    bready <= 1'b0;
    chk(32'({bvalid, bresp}), 32'({1'b1, er}));
  endtask
  task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
      input logic [1:0] er);
    int t;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1) && t < 50);
    rready <= 1'b0;
    chk(rdata & m, e);
    chk(32'({rvalid, rresp}), 32'({1'b1, er}));
  endtask
  // Selector is only read after reset, so each mode needs its own power-up
  task automatic power_up(input logic [2:0] sel, input logic [5:0] on, input logic st);
    @(posedge aclk);
    aresetn <= 1'b0;
    start_sel <= sel;
    want_on <= on;
    start_in <= st;
    {skew, short_en} <= 12'h000;
    cyc(16);
    aresetn <= 1'b1;
    cyc(20);
  endtask
  task automatic drv(input logic [5:0] on, input logic st);
    @(posedge aclk);
    want_on <= on;
    start_in <= st;
  endtask
  task automatic wait_out(input logic [1:0] e, input int n);
    int t;
    t = 0;
    while (safe_out !== e && t < n) begin
      @(posedge aclk);
      t++;
    end
    chk(32'(safe_out), 32'(e));
  endtask
  task automatic stay(input logic [1:0] e, input int n);
    logic [1:0] w;
    w = e;
    repeat (n) begin
      @(posedge aclk);
      if (safe_out !== e) w = safe_out;
    end
    chk(32'(w), 32'(e));
  endtask
  // ========================================
  // Scenarios
  task automatic t_sel();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      power_up(c, 6'h00, 1'b0);
      rdm(sisc_pkg::REG_STATUS, {10'h0, {6{c[0]}}, 16'h07ff},
        {10'h0, {6{c[0]}}, 5'h0, ~c[2], c[0], c[1], c, 1'b0, 4'h4}, sisc_pkg::RESP_OKAY);
    end
    rdm(12'h0fc, 32'hffffffff, 32'h0, sisc_pkg::RESP_SLVERR);
    axi_wr(12'h0fc, 32'h1, sisc_pkg::RESP_SLVERR);
    axi_wr(sisc_pkg::REG_STATUS, 32'hffffffff, sisc_pkg::RESP_OKAY);
    rdm(sisc_pkg::REG_STATUS, 32'h1f, 32'h04, sisc_pkg::RESP_OKAY);
  endtask
  task automatic t_auto();
    power_up(3'h4, 6'h00, 1'b1);
    stay(2'h0, 30);
    drv(6'h3f, 1'b1);
    wait_out(2'h3, 40);
    rdm(sisc_pkg::REG_STATUS, 32'h1f, 32'h18, sisc_pkg::RESP_OKAY);
    drv(6'h37, 1'b1);
    wait_out(2'h0, 50);
    cyc(60);
    drv(6'h3f, 1'b1);
    wait_out(2'h3, 40);
  endtask
  task automatic t_man();
    power_up(3'h0, 6'h3f, 1'b0);
    stay(2'h0, 50);
    drv(6'h3f, 1'b1);
    wait_out(2'h3, 40);
    drv(6'h3e, 1'b1);
    wait_out(2'h0, 50);
    cyc(60);
    drv(6'h3f, 1'b1);
    stay(2'h0, 60);
    drv(6'h3f, 1'b0);
    cyc(10);
    drv(6'h3f, 1'b1);
    wait_out(2'h3, 40);
  endtask
  task automatic t_mon();
    power_up(3'h2, 6'h3f, 1'b0);
    cyc(30);
    drv(6'h3f, 1'b1);
    cyc(int'(STRT) - 20);
    drv(6'h3f, 1'b0);
    stay(2'h0, 60);
    drv(6'h00, 1'b1);
    cyc(30);
    drv(6'h3f, 1'b1);
    cyc(int'(STRT));
    stay(2'h0, 40);
    drv(6'h3f, 1'b0);
    wait_out(2'h3, 40);
    drv(6'h3b, 1'b0);
    wait_out(2'h0, 50);
    cyc(60);
    drv(6'h3f, 1'b0);
    stay(2'h0, 60);
  endtask
  task automatic t_test();
    power_up(3'h5, 6'h3f, 1'b1);
    stay(2'h0, 60);
    rdm(sisc_pkg::REG_STATUS, 32'h0f, 32'h02, sisc_pkg::RESP_OKAY);
    drv(6'h38, 1'b1);
    cyc(60);
    drv(6'h3f, 1'b1);
    stay(2'h0, 40);
    drv(6'h07, 1'b1);
    cyc(60);
    drv(6'h3f, 1'b1);
    wait_out(2'h3, 60);
    rdm(sisc_pkg::REG_STATUS, 32'h3f0000, 32'h3f0000, sisc_pkg::RESP_OKAY);
  endtask
  task automatic t_flt();
    power_up(3'h4, 6'h3f, 1'b1);
    wait_out(2'h3, 40);
    skew <= 6'h04;
    wait_out(2'h0, 50);
    cyc(int'(SYNC) + 20);
    chk(32'(fault_out), 32'h1);
    rdm(sisc_pkg::REG_PAIR, 32'h3f3f3f, 32'h043b, sisc_pkg::RESP_OKAY);
    drv(6'h3b, 1'b1);
    skew <= 6'h00;
    cyc(40);
    chk(32'(fault_out), 32'h0);
    drv(6'h3f, 1'b1);
    wait_out(2'h3, 40);
    short_en <= 6'h10;
    cyc(140);
    short_en <= 6'h00;
    chk(32'({fault_out, safe_out}), 32'h4);
    rdm(sisc_pkg::REG_PAIR, 32'h3f3f3f, 32'h10002f, sisc_pkg::RESP_OKAY);
    axi_wr(sisc_pkg::REG_FCLR, 32'h10, sisc_pkg::RESP_OKAY);
    rdm(sisc_pkg::REG_FCLR, 32'hffffffff, 32'h0, sisc_pkg::RESP_OKAY);
    wait_out(2'h3, 40);
  endtask
  // ========================================
  // Sequence, verdict and watchdog
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    {aresetn, start_in, start_sel, want_on, skew, short_en} = '0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    n_mismatch = 0;
    checks_done = 0;
    t_sel();
    t_auto();
    t_man();
    t_mon();
    t_test();
    t_flt();
    report_and_stop();
  end
  // Whole run needs a few thousand cycles; this cuts a hang short
  initial begin
    cyc(20000);
    n_mismatch++;
    report_and_stop();
  end
endmodule
